// ==== rtl/imu_spi_sync.sv ====
// serial slave port, sync-clock input and data-ready pacing of the sensor
//
// How it works
// [RULE1] master idles 9 us between normal words
// [RULE2] burst words may follow with no gap
// [RULE3] serial output changes on falling clock edge
// [RULE4] serial input captured on rising clock edge
// [RULE5] fourth pin is general I/O or sync input
// [RULE6] sync pulse stays high at least 25 us
// [RULE7] data ready follows sync pulse by 670 us
// [RULE8] shift only with select low; high ends word
// [RULE9] mode 3, 16-bit words, msb first
// [RULE10] sclk max 1 MHz burst, 2 MHz else
// [RULE11] first pin pulses high after each sample
`timescale 1ns/1ps
`default_nettype none

module imu_spi_sync #(
  parameter int unsigned SYNC_DRDY_CYC = imu_pkg::SYNC_DRDY_CYC,
  parameter int unsigned SAMPLE_CYC    = imu_pkg::SAMPLE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // serial link
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output var  logic        spi_miso,
  output logic             spi_miso_oe,
  // word exchange with the sensor core
  input  wire logic [15:0] tx_word,
  output var  logic [15:0] rx_word,
  output var  logic        rx_valid,
  input  wire logic        burst_mode,
  output var  logic        stall_err,
  // fourth configurable pin
  input  wire logic        sync_mode,
  input  wire logic        aux_out_val,
  input  wire logic        aux_dir_out,
  output var  logic        aux_in_val,
  input  wire logic        aux_io_or_sync_in_i,
  output var  logic        aux_io_or_sync_in_o,
  output logic             aux_io_or_sync_in_oe,
  output var  logic        sync_width_err,
  // sample pacing
  output var  logic        data_ready_pin,
  output var  logic        sample_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: runs on the master's clock, which stops between frames

  logic        link_clr;
  logic [3:0]  rx_cnt_ff;
  logic [15:0] rx_shift_ff;
  logic [15:0] rx_last_ff;
  logic        rx_tgl_ff;
  logic [3:0]  tx_cnt_ff;
  logic        miso_ff;
  logic [15:0] tx_hold_ff;

  // select high clears the bit position, so a cut word is dropped
  assign link_clr = spi_cs_n | ~rst_n; // see [RULE8]

  // input side, rising edges; counter wraps so burst words run on
  always_ff @(posedge spi_sclk or posedge link_clr) begin
    if (link_clr) begin
      rx_cnt_ff   <= imu_pkg::BIT_CNT_RST;
      rx_shift_ff <= imu_pkg::WORD_RST;
    end else begin
      rx_shift_ff <= {rx_shift_ff[14:0], spi_mosi}; // see [RULE4] see [RULE9]
      rx_cnt_ff   <= rx_cnt_ff + 4'h1; // see [RULE2]
    end
  end

  // finished word and its toggle survive the frame's end
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_last_ff <= imu_pkg::WORD_RST;
      rx_tgl_ff  <= 1'b0;
    end else if (!spi_cs_n && rx_cnt_ff == imu_pkg::BIT_CNT_LAST) begin
      rx_last_ff <= {rx_shift_ff[14:0], spi_mosi}; // see [RULE9]
      rx_tgl_ff  <= ~rx_tgl_ff;
    end
  end

  // output side, falling edges; the first falling edge drives the msb
  always_ff @(negedge spi_sclk or posedge link_clr) begin
    if (link_clr) begin
      tx_cnt_ff <= imu_pkg::BIT_CNT_RST;
      miso_ff   <= 1'b0;
    end else begin
      miso_ff   <= tx_hold_ff[4'hF - tx_cnt_ff]; // see [RULE3] see [RULE9]
      tx_cnt_ff <= tx_cnt_ff + 4'h1; // see [RULE2]
    end
  end

  assign spi_miso    = miso_ff;
  // release the line while deselected so other slaves can share it
  assign spi_miso_oe = ~spi_cs_n; // see [RULE8]

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the reference domain

  logic [2:0] cs_sync_ff;
  logic [2:0] tgl_sync_ff;
  logic [2:0] aux_sync_ff;
  logic       cs_stable_ff;
  logic       tgl_stable_ff;
  logic       aux_stable_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_sync_ff  <= 3'h7;
      tgl_sync_ff <= 3'h0;
      aux_sync_ff <= 3'h0;
    end else begin
      cs_sync_ff  <= {cs_sync_ff[1:0], spi_cs_n};
      tgl_sync_ff <= {tgl_sync_ff[1:0], rx_tgl_ff};
      aux_sync_ff <= {aux_sync_ff[1:0], aux_io_or_sync_in_i};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_stable_ff  <= 1'b1;
      tgl_stable_ff <= 1'b0;
      aux_stable_ff <= 1'b0;
    end else begin
      if (cs_sync_ff[1] == cs_sync_ff[2]) begin
        cs_stable_ff <= cs_sync_ff[2];
      end
      if (tgl_sync_ff[1] == tgl_sync_ff[2]) begin
        tgl_stable_ff <= tgl_sync_ff[2];
      end
      if (aux_sync_ff[1] == aux_sync_ff[2]) begin
        aux_stable_ff <= aux_sync_ff[2];
      end
    end
  end

  logic cs_stable_q_ff;
  logic tgl_stable_q_ff;
  logic aux_stable_q_ff;
  logic word_done;
  logic frame_start;
  logic sync_rise;
  logic sync_fall;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_stable_q_ff  <= 1'b1;
      tgl_stable_q_ff <= 1'b0;
      aux_stable_q_ff <= 1'b0;
    end else begin
      cs_stable_q_ff  <= cs_stable_ff;
      tgl_stable_q_ff <= tgl_stable_ff;
      aux_stable_q_ff <= aux_stable_ff;
    end
  end

  assign word_done   = tgl_stable_ff ^ tgl_stable_q_ff;
  assign frame_start = cs_stable_q_ff & ~cs_stable_ff;
  assign sync_rise   = sync_mode & aux_stable_ff & ~aux_stable_q_ff;
  assign sync_fall   = sync_mode & ~aux_stable_ff & aux_stable_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // received word and transmit word hand-over

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_word  <= imu_pkg::WORD_RST;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= word_done;
      if (word_done) begin
        // stable: its toggle settled three edges after the word closed
        rx_word <= rx_last_ff;
      end
    end
  end

  // the link reads tx_hold_ff untimed: tx_word must stand a few cycles
  // past select falling; burst words need the slow clock for the hand-over
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_hold_ff <= imu_pkg::WORD_RST;
    end else if (cs_stable_ff || word_done) begin
      tx_hold_ff <= tx_word; // see [RULE2] see [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stall watch between normal-mode words

  logic [15:0] gap_cnt_ff;
  logic        seen_word_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap_cnt_ff   <= imu_pkg::CNT_RST;
      seen_word_ff <= 1'b0;
    end else if (word_done) begin
      gap_cnt_ff   <= imu_pkg::CNT_RST;
      seen_word_ff <= 1'b1;
    end else if (gap_cnt_ff < 16'(imu_pkg::STALL_CYC)) begin
      gap_cnt_ff <= gap_cnt_ff + 16'h0001;
    end
  end

  // flags a master that breaks the idle gap; the word is still served
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stall_err <= 1'b0;
    end else begin
      stall_err <= frame_start & ~burst_mode & seen_word_ff &
                   (gap_cnt_ff < 16'(imu_pkg::STALL_CYC)); // see [RULE1] see [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fourth pin: general I/O or sync input

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_io_or_sync_in_o <= 1'b0;
      aux_in_val          <= 1'b0;
    end else begin
      aux_io_or_sync_in_o <= aux_out_val;
      aux_in_val          <= aux_stable_ff;
    end
  end

  // never drive the pin while it carries the sync clock
  assign aux_io_or_sync_in_oe = ~sync_mode & aux_dir_out; // see [RULE5]

  // high-time check on each sync pulse
  logic [15:0] sync_hi_cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_hi_cnt_ff <= imu_pkg::CNT_RST;
    end else if (sync_rise) begin
      sync_hi_cnt_ff <= 16'h0001;
    end else if (aux_stable_ff && sync_hi_cnt_ff != 16'hFFFF) begin
      sync_hi_cnt_ff <= sync_hi_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_width_err <= 1'b0;
    end else begin
      sync_width_err <= sync_fall &
                        (sync_hi_cnt_ff < 16'(imu_pkg::SYNC_PULSE_CYC)); // see [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample sequencer and data-ready pulse

  imu_pkg::imu_seq_t seq_ff;
  imu_pkg::imu_seq_t nxt_seq;
  logic [15:0]       seq_cnt_ff;
  logic [15:0]       nxt_seq_cnt;
  logic [15:0]       rate_cnt_ff;
  logic              rate_tick;

  // free-running period used when no external sync paces sampling
  always_ff @(posedge ref_clk) begin
    if (!rst_n || sync_mode) begin
      rate_cnt_ff <= imu_pkg::CNT_RST;
    end else if (rate_tick) begin
      rate_cnt_ff <= imu_pkg::CNT_RST;
    end else begin
      rate_cnt_ff <= rate_cnt_ff + 16'h0001;
    end
  end

  assign rate_tick = ~sync_mode & (rate_cnt_ff == 16'(SAMPLE_CYC - 1)); // see [RULE5]

  always_comb begin
    nxt_seq     = seq_ff;
    nxt_seq_cnt = seq_cnt_ff;
    case (seq_ff)
      imu_pkg::SEQ_IDLE: begin
        if (sync_rise) begin
          nxt_seq     = imu_pkg::SEQ_WAIT;
          nxt_seq_cnt = 16'(SYNC_DRDY_CYC - 1); // see [RULE7]
        end else if (rate_tick) begin
          nxt_seq     = imu_pkg::SEQ_PULSE;
          nxt_seq_cnt = imu_pkg::DRDY_PULSE_CYC - 16'h0001;
        end
      end
      imu_pkg::SEQ_WAIT: begin
        // later sync edges are ignored until this sample is out
        if (seq_cnt_ff == imu_pkg::CNT_RST) begin
          nxt_seq     = imu_pkg::SEQ_PULSE;
          nxt_seq_cnt = imu_pkg::DRDY_PULSE_CYC - 16'h0001;
        end else begin
          nxt_seq_cnt = seq_cnt_ff - 16'h0001;
        end
      end
      imu_pkg::SEQ_PULSE: begin
        if (seq_cnt_ff == imu_pkg::CNT_RST) begin
          nxt_seq = imu_pkg::SEQ_IDLE;
        end else begin
          nxt_seq_cnt = seq_cnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_seq     = imu_pkg::SEQ_IDLE;
        nxt_seq_cnt = imu_pkg::CNT_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_ff     <= imu_pkg::SEQ_IDLE;
      seq_cnt_ff <= imu_pkg::CNT_RST;
    end else begin
      seq_ff     <= nxt_seq;
      seq_cnt_ff <= nxt_seq_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_ready_pin <= 1'b0;
      sample_tick    <= 1'b0;
    end else begin
      data_ready_pin <= (nxt_seq == imu_pkg::SEQ_PULSE); // see [RULE11] see [RULE7]
      sample_tick    <= (nxt_seq == imu_pkg::SEQ_PULSE) &&
                        (seq_ff != imu_pkg::SEQ_PULSE); // see [RULE11]
    end
  end

endmodule : imu_spi_sync

`default_nettype wire

// ==== include/imu_pkg.sv ====
// shared constants for the inertial sensor serial port and sample pacing
package imu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and word format
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned WORD_BITS      = 16;
  localparam logic [3:0]  BIT_CNT_RST    = 4'h0;
  localparam logic [3:0]  BIT_CNT_LAST   = 4'hF;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam int unsigned SYNC_STAGES    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // link timing, microseconds as printed
  localparam int unsigned STALL_US       = 9;
  localparam int unsigned SYNC_PULSE_US  = 25;
  localparam int unsigned SYNC_DRDY_US   = 670;

  // least times round up, a typical delay is taken as is
  localparam int unsigned STALL_CYC      = (STALL_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned SYNC_PULSE_CYC = (SYNC_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned SYNC_DRDY_CYC  = SYNC_DRDY_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // internal sample rate, tenths of samples per second
  localparam int unsigned SAMPLE_RATE_DSPS = 8192;
  localparam int unsigned SAMPLE_CYC       = (CLK_HZ * 10) / SAMPLE_RATE_DSPS;

  // data-ready high time, cycles
  localparam logic [15:0] DRDY_PULSE_CYC = 16'h0019;
  localparam logic [15:0] CNT_RST        = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // sample sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_PULSE
  } imu_seq_t;

endpackage : imu_pkg

// ==== verif/imu_spi_sync_props.sv ====
// checker on the serial, sync and data-ready ports
`timescale 1ns/1ps
`default_nettype none
module imu_spi_sync_props #(parameter int unsigned SYNC_DRDY_CYC = 40) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic rx_valid,
  input wire logic sync_mode,
  input wire logic aux_dir_out,
  input wire logic aux_io_or_sync_in_i,
  input wire logic aux_io_or_sync_in_oe,
  input wire logic data_ready_pin,
  input wire logic sample_tick
);
  // synchroniser adds three to six edges ahead of the fixed delay
  localparam int LO = SYNC_DRDY_CYC + 3;
  localparam int HI = SYNC_DRDY_CYC + 6;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_oe; spi_miso_oe == !spi_cs_n; endproperty
  a_oe: assert property (p_oe) else $error("miso enable off select");
  property p_idle; spi_cs_n |-> !spi_miso; endproperty
  a_idle: assert property (p_idle) else $error("miso not parked");
  property p_aux; aux_io_or_sync_in_oe == (!sync_mode && aux_dir_out); endproperty
  a_aux: assert property (p_aux) else $error("pin enable wrong");
  property p_sync;
    sync_mode && $rose(aux_io_or_sync_in_i) && !data_ready_pin |-> ##[LO:HI] $rose(data_ready_pin);
  endproperty
  a_sync: assert property (p_sync) else $error("sync to ready delay");
  property p_width; $rose(data_ready_pin) |-> ##24 data_ready_pin ##1 !data_ready_pin; endproperty
  a_width: assert property (p_width) else $error("ready width");
  property p_tick; $rose(data_ready_pin) |-> sample_tick ##1 !sample_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick missing");
  property p_cause; sample_tick |-> data_ready_pin && !$past(data_ready_pin); endproperty
  a_cause: assert property (p_cause) else $error("tick without ready rise");
  property p_rxv; rx_valid |=> !rx_valid; endproperty
  a_rxv: assert property (p_rxv) else $error("word strobe too long");
endmodule : imu_spi_sync_props
bind imu_spi_sync imu_spi_sync_props #(.SYNC_DRDY_CYC(SYNC_DRDY_CYC)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .rx_valid(rx_valid), .sync_mode(sync_mode),
  .aux_dir_out(aux_dir_out), .aux_io_or_sync_in_i(aux_io_or_sync_in_i),
  .aux_io_or_sync_in_oe(aux_io_or_sync_in_oe), .data_ready_pin(data_ready_pin),
  .sample_tick(sample_tick));
`default_nettype wire

// ==== verif/imu_host_bfm.sv ====
// serial master model: mode 3, msb first, clock only inside frames
`timescale 1ns/1ps
`default_nettype none
module imu_host_bfm (
  output var logic spi_sclk,
  output var logic spi_cs_n,
  output var logic spi_mosi,
  input wire logic spi_miso
);
  // wait out time zero so the link flops meet a clean clear edge
  initial begin
    #2;
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // keep low select for a burst, no idle gap then
  task automatic xfer(input logic [15:0] w, input int nbits, input bit keep,
                      output logic [15:0] r);
    r = 16'h0000;
    spi_cs_n = 1'b0;
    #20;
    for (int i = 15; i > 15 - nbits; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = w[i];
      #7.5;
      spi_sclk = 1'b1;
      r = {r[14:0], spi_miso};
      #7.5;
    end
    // released line shows the inverse so a stale bit cannot pass
    spi_mosi = ~spi_mosi;
    if (!keep) spi_cs_n = 1'b1;
  endtask : xfer
endmodule : imu_host_bfm
`default_nettype wire

// ==== verif/test_imu_spi_sync.sv ====
// self-checking bench for the serial port, sync input and data ready
`timescale 1ns/1ps
`default_nettype none
module test_imu_spi_sync;
  localparam int unsigned DRDY = 40;
  logic ref_clk = 1'b0, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [15:0] tx_word = 16'h0000, rx_word;
  logic rx_valid, stall_err, aux_in_val, aux_io_or_sync_in_o, aux_io_or_sync_in_oe;
  logic sync_width_err, data_ready_pin, sample_tick, aux_drv = 1'b0;
  logic burst_mode = 1'b0, sync_mode = 1'b0, aux_out_val = 1'b0, aux_dir_out = 1'b0;
  wire logic aux_io_or_sync_in_i = aux_io_or_sync_in_oe ? aux_io_or_sync_in_o : aux_drv;
  int err_total = 0, total_checks = 0, n_stall = 0, n_werr = 0, n_drdy = 0;
  int cyc = 0, t_tick = 0, gap = 0;
  logic [31:0] seed = 32'h0001_0575;
  logic [15:0] exp_q[$];
  always #20 ref_clk = ~ref_clk;
  imu_spi_sync #(.SYNC_DRDY_CYC(DRDY), .SAMPLE_CYC(60)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .tx_word(tx_word), .rx_word(rx_word), .rx_valid(rx_valid), .burst_mode(burst_mode),
    .stall_err(stall_err), .sync_mode(sync_mode), .aux_out_val(aux_out_val),
    .aux_dir_out(aux_dir_out), .aux_in_val(aux_in_val),
    .aux_io_or_sync_in_i(aux_io_or_sync_in_i), .aux_io_or_sync_in_o(aux_io_or_sync_in_o),
    .aux_io_or_sync_in_oe(aux_io_or_sync_in_oe), .sync_width_err(sync_width_err),
    .data_ready_pin(data_ready_pin), .sample_tick(sample_tick));
  imu_host_bfm i_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
                       .spi_miso(spi_miso));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  task automatic word(input int nbits, input bit keep);
    logic [15:0] w;
    logic [15:0] r;
    seed = lfsr(seed);
    w = seed[15:0];
    if (nbits == 16) exp_q.push_back(w);
    i_host.xfer(w, nbits, keep, r);
    if (nbits == 16) chk("miso_word", r, tx_word);
    // new send word only between frames: the fast link outruns the hand-over
    if (!keep) begin
      cycles(1);
      tx_word = seed[31:16];
    end
  endtask : word
  ////////////////////////////////////////////////////////////////////////////
  // scoreboard side: rx words against the queue, event counts
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
    if (rx_valid === 1'b1 && exp_q.size() == 0) begin
      chk("rx_extra", 16'h0001, 16'h0000);
    end else if (rx_valid === 1'b1) begin
      chk("rx_word", rx_word, exp_q.pop_front());
    end
    if (stall_err === 1'b1) n_stall++;
    if (sync_width_err === 1'b1) n_werr++;
    if (sample_tick === 1'b1) begin
      n_drdy++;
      gap = cyc - t_tick;
      t_tick = cyc;
    end
  end
  initial begin
    // a real falling edge at time one clears the link flops
    #1 rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cycles(5);
    tx_word = seed[31:16];
    cycles(4);
    for (int i = 0; i < 4; i++) begin
      word(16, 1'b0);
      cycles(240);
    end
    chk("stall_spaced", 16'(n_stall), 16'h0000);
    word(16, 1'b0);
    cycles(20);
    word(16, 1'b0);
    cycles(240);
    chk("stall_close", 16'(n_stall), 16'h0001);
    $display("normal words done");
    burst_mode = 1'b1;
    word(16, 1'b1);
    word(16, 1'b1);
    word(16, 1'b0);
    cycles(240);
    burst_mode = 1'b0;
    chk("stall_burst", 16'(n_stall), 16'h0001);
    $display("burst done");
    word(8, 1'b0);
    cycles(240);
    word(16, 1'b0);
    cycles(240);
    chk("queue_left", 16'(exp_q.size()), 16'h0000);
    $display("partial word done");
    cycles(200);
    chk("sample_gap", 16'(gap), 16'h003C);
    aux_dir_out = 1'b1;
    aux_out_val = 1'b1;
    cycles(4);
    chk("pin_out", {15'h0000, aux_io_or_sync_in_o}, 16'h0001);
    aux_out_val = 1'b0;
    cycles(4);
    chk("pin_out0", {15'h0000, aux_io_or_sync_in_o}, 16'h0000);
    aux_dir_out = 1'b0;
    aux_drv = 1'b1;
    cycles(6);
    chk("pin_in", {15'h0000, aux_in_val}, 16'h0001);
    aux_drv = 1'b0;
    $display("general pin done");
    // pin must settle low, and a free-running pulse end, before sync mode
    cycles(100);
    sync_mode = 1'b1;
    cycles(30);
    n_drdy = 0;
    aux_drv = 1'b1;
    cycles(10);
    aux_drv = 1'b0;
    cycles(DRDY + 40);
    chk("width_err_short", 16'(n_werr), 16'h0001);
    chk("ready_short", 16'(n_drdy), 16'h0001);
    // source keeps the minimum sync period between rises
    cycles(22760);
    aux_drv = 1'b1;
    cycles(700);
    aux_drv = 1'b0;
    cycles(40);
    chk("width_err_long", 16'(n_werr), 16'h0001);
    chk("ready_long", 16'(n_drdy), 16'h0002);
    $display("sync input done");
    end_sim();
  end
endmodule : test_imu_spi_sync
`default_nettype wire
